// ### logic/beam_control_serial_loader.sv
// Serial loader for pointer bank, status chain, two storage stages and output mux
`timescale 1ns/1ns
`default_nettype none
module beam_control_serial_loader (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic serial_clk,
    input wire logic status_select_n,
    input wire logic status_serial_in,
    output logic status_serial_out,
    input wire logic control_serial_in,
    input wire logic control_enable_n,
    input wire logic first_stage_write_trigger,
    input wire logic sync_trigger,
    input wire logic receive_external_switch,
    input wire logic transmit_external_switch,
    input wire logic reset_enable,
    output logic receive_switch_select,
    output beam_control_pkg::phase_type phase_control [beam_control_pkg::CHANNEL_COUNT],
    output logic [5:0] atten_control [beam_control_pkg::CHANNEL_COUNT],
    output logic [beam_control_pkg::CHANNEL_COUNT-1:0] tx_switch,
    output logic [beam_control_pkg::CHANNEL_COUNT-1:0] rx_switch,
    output beam_control_pkg::common_type common_control_n
);
    import beam_control_pkg::*;

    // ----------------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------------
    logic [PIN_COUNT-1:0] pins;
    logic [PIN_COUNT-1:0] pin_level;
    logic [PIN_COUNT-1:0] pin_rise;
    logic [PIN_COUNT-1:0] pin_fall;

    assign pins = {reset_enable, transmit_external_switch, receive_external_switch,
                   sync_trigger, first_stage_write_trigger, control_enable_n,
                   control_serial_in, status_serial_in, status_select_n, serial_clk};

    pin_sampler #(
        .WIDTH(PIN_COUNT),
        .IDLE(PIN_IDLE)
    ) sampler (
        .core_clk(core_clk),
        .rst(rst),
        .pin_in(pins),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    logic clear;
    logic sclk_rise;
    logic sclk_fall;

    assign clear = rst | pin_level[PIN_RESET_EN];
    assign sclk_rise = pin_rise[PIN_SERIAL_CLK];
    assign sclk_fall = pin_fall[PIN_SERIAL_CLK];

    // ----------------------------------------------------------------
    // Control chain
    // ----------------------------------------------------------------
    logic [CONTROL_BITS-1:0] control_shift_chain;
    logic commit_pending;

    always_ff @(posedge core_clk) begin
        if (clear) begin
            control_shift_chain <= CONTROL_RESET;
        end else if (!pin_level[PIN_CONTROL_EN_N] && sclk_rise) begin
            control_shift_chain <= {control_shift_chain[CONTROL_BITS-2:0],
                                    pin_level[PIN_CONTROL_IN]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (clear) begin
            commit_pending <= 1'b0;
        end else if (pin_rise[PIN_CONTROL_EN_N]) begin
            commit_pending <= 1'b1;
        end else if (sclk_rise || pin_fall[PIN_CONTROL_EN_N]) begin
            commit_pending <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Pointer bank
    // ----------------------------------------------------------------
    logic [POINTER_BITS-1:0] address_pointer_bank [POINTER_COUNT];
    logic [3:0] control_addr;
    logic [POINTER_BITS-1:0] control_data;
    logic [INDEX_BITS-1:0] store_write_index;
    logic [INDEX_BITS-1:0] store_read_index;

    assign control_addr = control_shift_chain[CONTROL_ADDR_LSB +: 4];
    assign control_data = control_shift_chain[CONTROL_DATA_LSB +: POINTER_BITS];

    // entries 0 and 1 low bits
    assign store_write_index = address_pointer_bank[WRITE_POINTER_ADDR][INDEX_BITS-1:0];
    assign store_read_index = address_pointer_bank[READ_POINTER_ADDR][INDEX_BITS-1:0];

    always_ff @(posedge core_clk) begin
        if (clear) begin
            for (int k = 0; k < POINTER_COUNT; k++) begin
                address_pointer_bank[k] <= POINTER_RESET;
            end
        end else if (commit_pending && sclk_rise) begin
            address_pointer_bank[control_addr] <= control_data;
        end
    end

    // ----------------------------------------------------------------
    // Status chain
    // ----------------------------------------------------------------
    logic [FRAME_BITS-1:0] status_chain;
    logic [6:0] frame_count;
    logic [6:0] readback_index;
    logic frame_full;
    logic status_shift;

    assign frame_full = (frame_count == FRAME_COUNT_FULL);
    assign status_shift = !pin_level[PIN_SELECT_N] && sclk_fall;

    always_ff @(posedge core_clk) begin
        if (clear || pin_fall[PIN_SELECT_N]) begin
            frame_count <= FRAME_COUNT_RESET;
        end else if (status_shift && !frame_full) begin
            frame_count <= frame_count + 7'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clear) begin
            status_chain <= FRAME_RESET;
        end else if (status_shift && !frame_full && !pin_fall[PIN_SELECT_N]) begin
            status_chain <= {pin_level[PIN_STATUS_IN], status_chain[FRAME_BITS-1:1]};
        end
    end

    // ----------------------------------------------------------------
    // Readback
    // ----------------------------------------------------------------

    // read back from frame bit 0
    always_ff @(posedge core_clk) begin
        if (clear || pin_fall[PIN_SELECT_N]) begin
            readback_index <= FRAME_COUNT_RESET;
        end else if (status_shift && frame_full && readback_index < FRAME_COUNT_FULL - 7'h01) begin
            readback_index <= readback_index + 7'h01;
        end
    end

    // first bit in is frame bit 0
    always_ff @(posedge core_clk) begin
        if (clear) begin
            status_serial_out <= 1'b0;
        end else if (frame_full) begin
            status_serial_out <= status_chain[readback_index];
        end else begin
            status_serial_out <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Switch select
    // ----------------------------------------------------------------
    logic rx_state;
    logic tx_state;

    assign rx_state = pin_level[PIN_RX_SWITCH] && !pin_level[PIN_TX_SWITCH];
    assign tx_state = pin_level[PIN_TX_SWITCH] && !pin_level[PIN_RX_SWITCH];

    always_ff @(posedge core_clk) begin
        if (clear) begin
            receive_switch_select <= 1'b0;
        end else begin
            receive_switch_select <= pin_level[PIN_RX_SWITCH];
        end
    end

    // ----------------------------------------------------------------
    // Per-channel storage stages and output mux
    // ----------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < CHANNEL_COUNT; c++) begin : channel
            localparam int LSB = FRAME_BITS - (c + 1) * SEGMENT_BITS;
            segment_type channel_status_segment;
            segment_type first_stage_store [STORE_DEPTH];
            segment_type second_stage_register;

            assign channel_status_segment = status_chain[LSB +: SEGMENT_BITS];

            always_ff @(posedge core_clk) begin
                if (clear) begin
                    for (int k = 0; k < STORE_DEPTH; k++) begin
                        first_stage_store[k] <= SEGMENT_RESET;
                    end
                end else if (pin_rise[PIN_WRITE_TRIG]) begin
                    first_stage_store[store_write_index] <= channel_status_segment;
                end
            end

            always_ff @(posedge core_clk) begin
                if (clear) begin
                    second_stage_register <= SEGMENT_RESET;
                end else if (pin_rise[PIN_SYNC_TRIG]) begin
                    second_stage_register <= first_stage_store[store_read_index];
                end
            end

            always_ff @(posedge core_clk) begin
                if (clear) begin
                    phase_control[c] <= '0;
                    atten_control[c] <= '0;
                end else if (pin_level[PIN_RX_SWITCH]) begin
                    phase_control[c] <= second_stage_register[RX_PHASE_LSB +: PHASE_BITS];
                    atten_control[c] <= second_stage_register[RX_ATTEN_LSB +: ATTEN_BITS];
                end else begin
                    phase_control[c] <= second_stage_register[TX_PHASE_LSB +: PHASE_BITS];
                    atten_control[c] <= {2'b00,
                        second_stage_register[TX_ATTEN_LSB +: TX_ATTEN_BITS]};
                end
            end

            always_ff @(posedge core_clk) begin
                if (clear) begin
                    tx_switch[c] <= 1'b0;
                    rx_switch[c] <= 1'b0;
                end else begin
                    tx_switch[c] <= tx_state && second_stage_register[TX_ENABLE_POS];
                    rx_switch[c] <= rx_state && second_stage_register[RX_ENABLE_POS];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Common segment stages
    // ----------------------------------------------------------------
    common_type common_first_stage;
    common_type common_second_stage;

    always_ff @(posedge core_clk) begin
        if (clear) begin
            common_first_stage <= COMMON_RESET;
        end else if (pin_rise[PIN_WRITE_TRIG]) begin
            common_first_stage <= status_chain[COMMON_BITS-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (clear) begin
            common_second_stage <= COMMON_RESET;
        end else if (pin_rise[PIN_SYNC_TRIG]) begin
            common_second_stage <= common_first_stage;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clear) begin
            common_control_n <= COMMON_RESET;
        end else begin
            common_control_n <= common_second_stage;
        end
    end

endmodule
`default_nettype wire

// ### common/beam_control_pkg.sv
// Shared constants and types of the beam-control serial loader
package beam_control_pkg;

    // ----------------------------------------------------------------
    // Frame and chain geometry
    // ----------------------------------------------------------------
    localparam int CHANNEL_COUNT = 4;
    localparam int SEGMENT_BITS = 27;
    localparam int COMMON_BITS = 14;
    localparam int FRAME_BITS = 122;
    localparam int CONTROL_BITS = 12;
    localparam int POINTER_COUNT = 16;
    localparam int POINTER_BITS = 8;
    localparam int STORE_DEPTH = 32;
    localparam int INDEX_BITS = 5;
    localparam int PHASE_BITS = 6;
    localparam int ATTEN_BITS = 6;
    localparam int TX_ATTEN_BITS = 4;

    // ----------------------------------------------------------------
    // Control chain fields and pointer entries
    // ----------------------------------------------------------------
    localparam int CONTROL_ADDR_LSB = 8;
    localparam int CONTROL_DATA_LSB = 0;
    localparam logic [3:0] WRITE_POINTER_ADDR = 4'h0;
    localparam logic [3:0] READ_POINTER_ADDR = 4'h1;

    // ----------------------------------------------------------------
    // Bit positions inside one channel segment
    // ----------------------------------------------------------------
    localparam int RX_ENABLE_POS = 0;
    localparam int TX_ENABLE_POS = 1;
    localparam int TX_PHASE_LSB = 3;
    localparam int RX_PHASE_LSB = 9;
    localparam int TX_ATTEN_LSB = 15;
    localparam int RX_ATTEN_LSB = 21;

    // ----------------------------------------------------------------
    // Counts and values after reset
    // ----------------------------------------------------------------
    localparam logic [6:0] FRAME_COUNT_FULL = 7'h7a;
    localparam logic [6:0] FRAME_COUNT_RESET = 7'h00;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [11:0] CONTROL_RESET = 12'h000;
    localparam logic [121:0] FRAME_RESET = 122'h0;
    localparam logic [26:0] SEGMENT_RESET = 27'h0000000;
    localparam logic [13:0] COMMON_RESET = 14'h0000;

    // ----------------------------------------------------------------
    // Pin sampler lanes and their idle levels
    // ----------------------------------------------------------------
    localparam int PIN_COUNT = 10;
    localparam int PIN_SERIAL_CLK = 0;
    localparam int PIN_SELECT_N = 1;
    localparam int PIN_STATUS_IN = 2;
    localparam int PIN_CONTROL_IN = 3;
    localparam int PIN_CONTROL_EN_N = 4;
    localparam int PIN_WRITE_TRIG = 5;
    localparam int PIN_SYNC_TRIG = 6;
    localparam int PIN_RX_SWITCH = 7;
    localparam int PIN_TX_SWITCH = 8;
    localparam int PIN_RESET_EN = 9;
    localparam logic [9:0] PIN_IDLE = 10'h012;

    typedef logic [SEGMENT_BITS-1:0] segment_type;
    typedef logic [COMMON_BITS-1:0] common_type;
    typedef logic [PHASE_BITS-1:0] phase_type;

endpackage

// ### logic/pin_sampler.sv
// Three-stage pin sampler with agreement filter and edge pulses
`timescale 1ns/1ns
`default_nettype none
module pin_sampler #(
    parameter int WIDTH = 10,
    parameter logic [WIDTH-1:0] IDLE = '0
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : lane
            logic stage1;
            logic stage2;
            logic stage3;

            // ------------------------------------------------------
            // Synchroniser chain
            // ------------------------------------------------------
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    stage1 <= IDLE[i];
                    stage2 <= IDLE[i];
                    stage3 <= IDLE[i];
                end else begin
                    stage1 <= pin_in[i];
                    stage2 <= stage1;
                    stage3 <= stage2;
                end
            end

            // ------------------------------------------------------
            // Accepted level and edge pulses
            // ------------------------------------------------------
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    level[i] <= IDLE[i];
                    rise[i] <= 1'b0;
                    fall[i] <= 1'b0;
                end else begin
                    rise[i] <= 1'b0;
                    fall[i] <= 1'b0;
                    if (stage2 == stage3 && stage3 != level[i]) begin
                        level[i] <= stage3;
                        rise[i] <= stage3;
                        fall[i] <= ~stage3;
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### verif/beam_control_serial_loader_chk.sv
// Port-level assertions for the beam-control serial loader
`timescale 1ns/1ns
`default_nettype none
module beam_control_serial_loader_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic serial_clk,
    input wire logic status_select_n,
    input wire logic status_serial_in,
    input wire logic status_serial_out,
    input wire logic control_serial_in,
    input wire logic control_enable_n,
    input wire logic first_stage_write_trigger,
    input wire logic sync_trigger,
    input wire logic receive_external_switch,
    input wire logic transmit_external_switch,
    input wire logic reset_enable,
    input wire logic receive_switch_select,
    input wire beam_control_pkg::phase_type phase_control [beam_control_pkg::CHANNEL_COUNT],
    input wire logic [5:0] atten_control [beam_control_pkg::CHANNEL_COUNT],
    input wire logic [beam_control_pkg::CHANNEL_COUNT-1:0] tx_switch,
    input wire logic [beam_control_pkg::CHANNEL_COUNT-1:0] rx_switch,
    input wire beam_control_pkg::common_type common_control_n
);
    import beam_control_pkg::*;
    logic [3:0] ctl_now;
    logic [3:0] ctl_prev;
    logic [3:0] quiet_cnt;
    logic [3:0] idle_cnt;
    logic [69:0] outs;
    logic [1:0] tx_att_hi;
    assign ctl_now = {sync_trigger, receive_external_switch, transmit_external_switch, reset_enable};
    assign outs = {phase_control[0], phase_control[1], phase_control[2], phase_control[3],
        atten_control[0], atten_control[1], atten_control[2], atten_control[3],
        tx_switch, rx_switch, common_control_n};
    assign tx_att_hi = atten_control[0][5:4] | atten_control[1][5:4] | atten_control[2][5:4]
        | atten_control[3][5:4];
    // Cycles since any output-steering input moved
    always_ff @(posedge core_clk) begin
        ctl_prev <= ctl_now;
        if (rst || ctl_prev != ctl_now) begin
            quiet_cnt <= 4'h0;
        end else if (quiet_cnt != 4'hf) begin
            quiet_cnt <= quiet_cnt + 4'h1;
        end
    end
    // Cycles with the status chain deselected
    always_ff @(posedge core_clk) begin
        if (rst || !status_select_n) begin
            idle_cnt <= 4'h0;
        end else if (idle_cnt != 4'hf) begin
            idle_cnt <= idle_cnt + 4'h1;
        end
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence rx_rise;
        $rose(receive_external_switch);
    endsequence
    sequence frame_begin;
        $fell(status_select_n) ##6 1'b1;
    endsequence
    AST_RESET_CLEARS: assert property ($fell(rst) |-> outs == '0 && !status_serial_out)
        else $error("outputs not clear after reset");
    AST_HOLD_CLEARS: assert property (reset_enable [*8] |-> outs == '0)
        else $error("outputs not held clear by reset enable");
    AST_SWITCH_EXCLUSIVE: assert property ((tx_switch & rx_switch) == '0)
        else $error("transmit and receive switch on together");
    AST_RX_MODE: assert property (|rx_switch && $stable(receive_switch_select) |-> receive_switch_select)
        else $error("receive switch on outside receive mode");
    AST_TX_ATTEN: assert property (!receive_switch_select && $stable(receive_switch_select) |-> tx_att_hi == 2'b00)
        else $error("transmit attenuation upper bits set");
    AST_SELECT_RISE: assert property (rx_rise |-> !receive_switch_select [*2] ##[1:4] receive_switch_select)
        else $error("switch select did not follow receive input");
    AST_OUTPUTS_HOLD: assert property (quiet_cnt >= 4'ha |-> $stable(outs))
        else $error("outputs moved without trigger or switch");
    AST_READBACK_HOLD: assert property (idle_cnt >= 4'ha && quiet_cnt >= 4'ha |-> $stable(status_serial_out))
        else $error("readback moved while deselected");
    AST_READBACK_QUIET: assert property (frame_begin |-> !status_serial_out [*8])
        else $error("readback active before frame full");
endmodule
bind beam_control_serial_loader beam_control_serial_loader_chk i_chk (.core_clk, .rst, .serial_clk,
    .status_select_n, .status_serial_in, .status_serial_out, .control_serial_in, .control_enable_n,
    .first_stage_write_trigger, .sync_trigger, .receive_external_switch, .transmit_external_switch,
    .reset_enable, .receive_switch_select, .phase_control, .atten_control, .tx_switch, .rx_switch,
    .common_control_n);
`default_nettype wire

// ### verif/beam_controller_model.sv
// Behavioural beam controller driving the serial link pins
`timescale 1ns/1ns
`default_nettype none
module beam_controller_model (
    output logic serial_clk,
    output logic status_select_n,
    output logic status_serial_in,
    output logic control_serial_in,
    output logic control_enable_n
);
    localparam int HALF = 160;
    initial begin
        serial_clk = 1'b0;
        status_select_n = 1'b1;
        status_serial_in = 1'b0;
        control_serial_in = 1'b0;
        control_enable_n = 1'b1;
    end
    task automatic ctl_word(input logic [11:0] w);
        control_enable_n = 1'b0;
        for (int i = 11; i >= 0; i--) begin
            control_serial_in = w[i];
            #HALF serial_clk = 1'b1;
            #HALF serial_clk = 1'b0;
        end
        control_enable_n = 1'b1;
        control_serial_in = ~w[0];
        #HALF serial_clk = 1'b1;
        #HALF serial_clk = 1'b0;
        #HALF;
    endtask
    task automatic frame(input logic [121:0] f);
        status_select_n = 1'b0;
        for (int i = 0; i < 122; i++) begin
            #HALF serial_clk = 1'b1;
            status_serial_in = f[i];
            #HALF serial_clk = 1'b0;
        end
        #HALF status_serial_in = ~f[121];
    endtask
    task automatic tick();
        #HALF serial_clk = 1'b1;
        #HALF serial_clk = 1'b0;
        #HALF;
    endtask
    // deselect, data line no longer valid
    task automatic deselect();
        status_select_n = 1'b1;
        status_serial_in = ~status_serial_in;
    endtask
endmodule
`default_nettype wire

// ### verif/beam_control_serial_loader_tb.sv
// Self-checking bench for the beam-control serial loader
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end
module beam_control_serial_loader_tb;
    import beam_control_pkg::*;
    typedef struct {
        segment_type seg;
        common_type com;
        logic [4:0] idx;
        logic rx;
        logic tx;
        logic [3:0] txs;
        logic [3:0] rxs;
    } row_type;
    logic core_clk, rst, serial_clk, status_select_n, status_serial_in, status_serial_out;
    logic control_serial_in, control_enable_n, first_stage_write_trigger, sync_trigger;
    logic receive_external_switch, transmit_external_switch, reset_enable, receive_switch_select;
    phase_type phase_control [CHANNEL_COUNT];
    logic [5:0] atten_control [CHANNEL_COUNT];
    logic [CHANNEL_COUNT-1:0] tx_switch;
    logic [CHANNEL_COUNT-1:0] rx_switch;
    common_type common_control_n;
    logic [121:0] f;
    int n_mismatch = 0;
    int total_checks = 0;
    // Segment, common, store index, switch pins, expected switch outputs
    row_type rows [4] = '{
        '{27'h7ffff03, 14'h2a55, 5'h00, 1'b1, 1'b0, 4'h0, 4'hf},
        '{27'h0a5a5a3, 14'h15aa, 5'h1f, 1'b0, 1'b1, 4'hf, 4'h0},
        '{27'h5555553, 14'h3fff, 5'h05, 1'b1, 1'b1, 4'h0, 4'h0},
        '{27'h2aaaaa8, 14'h0001, 5'h10, 1'b0, 1'b1, 4'h0, 4'h0}};
    beam_controller_model i_ctrl (.serial_clk, .status_select_n, .status_serial_in,
        .control_serial_in, .control_enable_n);
    beam_control_serial_loader i_dut (.core_clk, .rst, .serial_clk, .status_select_n,
        .status_serial_in, .status_serial_out, .control_serial_in, .control_enable_n,
        .first_stage_write_trigger, .sync_trigger, .receive_external_switch,
        .transmit_external_switch, .reset_enable, .receive_switch_select, .phase_control,
        .atten_control, .tx_switch, .rx_switch, .common_control_n);
    function automatic segment_type seg_of(row_type r, int i);
        return r.seg ^ (segment_type'(i) << TX_PHASE_LSB) ^ (segment_type'(i) << RX_PHASE_LSB);
    endfunction
    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic pulse(input logic sync);
        first_stage_write_trigger = !sync;
        sync_trigger = sync;
        wait_n(8);
        first_stage_write_trigger = 1'b0;
        sync_trigger = 1'b0;
        wait_n(8);
    endtask
    task automatic check_outputs(row_type r);
        segment_type s;
        for (int i = 0; i < CHANNEL_COUNT; i++) begin
            s = seg_of(r, i);
            `CHK("phase", (r.rx ? s[RX_PHASE_LSB +: 6] : s[TX_PHASE_LSB +: 6]), phase_control[i])
            `CHK("atten", (r.rx ? s[RX_ATTEN_LSB +: 6] : {2'b00, s[TX_ATTEN_LSB +: 4]}), atten_control[i])
        end
        `CHK("tx_switch", r.txs, tx_switch)
        `CHK("rx_switch", r.rxs, rx_switch)
        `CHK("rx_select", r.rx, receive_switch_select)
        `CHK("common", rows[3].com, common_control_n)
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        rst = 1'b1;
        {first_stage_write_trigger, sync_trigger, reset_enable} = 3'b000;
        {receive_external_switch, transmit_external_switch} = 2'b00;
        wait_n(4);
        rst = 1'b0;
        wait_n(1500);
        `CHK("clear", 1'b0, (|{tx_switch, rx_switch, common_control_n, phase_control[0]}))
        foreach (rows[k]) begin
            i_ctrl.ctl_word({WRITE_POINTER_ADDR, 3'b000, rows[k].idx});
            f = {seg_of(rows[k], 0), seg_of(rows[k], 1), seg_of(rows[k], 2), seg_of(rows[k], 3), rows[k].com};
            i_ctrl.frame(f);
            wait_n(8);
            `CHK("readback0", f[0], status_serial_out)
            i_ctrl.tick();
            wait_n(8);
            `CHK("readback1", f[1], status_serial_out)
            i_ctrl.deselect();
            pulse(1'b0);
        end
        for (int k = 3; k >= 0; k--) begin
            receive_external_switch = rows[k].rx;
            transmit_external_switch = rows[k].tx;
            i_ctrl.ctl_word({READ_POINTER_ADDR, 3'b000, rows[k].idx});
            i_ctrl.ctl_word(12'h2ea);
            pulse(1'b1);
            check_outputs(rows[k]);
        end
        {receive_external_switch, transmit_external_switch} = 2'b01;
        wait_n(10);
        `CHK("mux_tx", rows[0].seg[TX_PHASE_LSB +: 6], phase_control[0])
        `CHK("tx_on", 4'hf, tx_switch)
        reset_enable = 1'b1;
        wait_n(10);
        `CHK("held", 1'b0, (|{tx_switch, rx_switch, common_control_n, phase_control[1]}))
        reset_enable = 1'b0;
        wait_n(10);
        pulse(1'b1);
        `CHK("store_clear", 14'h0000, common_control_n)
        tally_and_finish();
    end
endmodule
`default_nettype wire
